// ### logic/bmon_pkg.sv
// Package with register map, field layout and types of the bus monitor
package bmon_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] BMON_OFS_CTRL1 = 12'h000;
  localparam logic [11:0] BMON_OFS_TRACE_CTRL = 12'h004;
  localparam logic [11:0] BMON_OFS_SEQ_WIN = 12'h008;
  localparam logic [11:0] BMON_OFS_STATE = 12'h00c;
  localparam logic [11:0] BMON_OFS_CMP_A = 12'h010;
  localparam logic [11:0] BMON_OFS_CMP_B = 12'h014;
  localparam logic [11:0] BMON_OFS_CMP_C = 12'h018;
  localparam logic [11:0] BMON_OFS_CMP_WIN = 12'h01c;
  localparam logic [11:0] BMON_OFS_TRACE_CNT = 12'h020;
  localparam logic [11:0] BMON_OFS_TRACE_DATA = 12'h024;

  // ****************************************
  // Field positions of control register 1
  // ****************************************
  localparam int BMON_C1_ARM = 7;
  localparam int BMON_C1_FORCE_TRIGGER = 6;
  localparam int BMON_C1_BDM = 4;
  localparam int BMON_C1_BRK = 3;
  localparam int BMON_C1_BANK_HI = 1;
  localparam int BMON_C1_BANK_LO = 0;
  localparam logic [7:0] BMON_C1_WMASK = 8'h9b;
  localparam logic [7:0] BMON_C1_RESET = 8'h00;

  // Trace control fields: bit0 source select, bit1 end align, bits 3:2 mode
  localparam int BMON_TC_SRC = 0;
  localparam int BMON_TC_ALIGN = 1;
  localparam logic [7:0] BMON_TC_RESET = 8'h00;

  // Bank select codes
  localparam logic [1:0] BMON_BANK_A = 2'h0;
  localparam logic [1:0] BMON_BANK_B = 2'h1;
  localparam logic [1:0] BMON_BANK_C = 2'h2;
  localparam logic [1:0] BMON_BANK_NONE = 2'h3;

  // Trace buffer geometry, row = 2 info bits + 18 address bits
  localparam int BMON_DEPTH = 64;
  localparam int BMON_PTR_W = 6;
  localparam int BMON_ROW_W = 20;
  localparam int BMON_ADDR_W = 18;
  localparam int BMON_PAGE_LSB = 6; // 64-byte boundary
  localparam logic [1:0] BMON_INFO_SHORT = 2'h0;
  localparam logic [1:0] BMON_INFO_FULL = 2'h3;
  localparam logic [BMON_PTR_W-1:0] BMON_END_HALF = 6'h1f;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {BMON_MODE_NORMAL, BMON_MODE_LOOP, BMON_MODE_DETAIL, BMON_MODE_PURE_PC} bmon_mode_t;
  typedef enum logic [1:0] {BMON_ST_IDLE, BMON_ST_S1, BMON_ST_S2, BMON_ST_S3} bmon_seq_t;

  // Processor bus activity observed by the monitor
  typedef struct packed {
    logic valid;
    logic [17:0] addr;
    logic [7:0] data;
    logic write;
    logic word;
    logic free;
    logic fetch;
    logic opcode_exec;
    logic cof_src;
    logic cof_dst;
    logic cof_vec;
  } bmon_cpu_t;

  // Mode status from the background debug side
  typedef struct packed {
    logic enabled;
    logic active;
    logic hw_access;
    logic secure;
    logic bgnd_cmd;
  } bmon_bdm_t;

endpackage

// ### logic/bmon_top.sv
// Bus monitor: comparators, sequencer, trace buffer and breakpoint control
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns

// Function
// - Secured device: no tracing, comparator breakpoints still possible.
// - Ignore CPU activity during background accesses or active background mode.
// - Entering background mode by command leaves the armed state unchanged.
// - Armed bit is read/write; cleared on session end or untraced breakpoint.
// - Setting armed bit moves the sequencer to its first state.
// - Force-trigger write of 1 triggers immediately when already armed; reads zero; zero ignored.
// - With trace source cleared, a trigger starts no tracing.
// - Begin-aligned tracing in progress is unaffected by force trigger.
// - Secured device: force trigger cannot start a tracing session.
// - Writing force-trigger and armed together ends the session.
// - Breakpoint target bit picks background entry or software interrupt.
// - Breakpoint-request bit: final state requests break, after tracing if tracing.
// - Bank select picks comparator window and the register below it.
// - Bank codes: A/ctl1, B/ctl2, C/ctl3, none/match flags.
// - Normal and loop modes store change-of-flow addresses only.
// - Loop mode shadows stored address; equal next source address suppressed.
// - Loop mode still records repeated destination and vector addresses.
// - Detail mode stores address bits 17:8 and data with size and direction bits.
// - Detail mode records all cycles except free and opcode fetch.
// - Compressed mode stores every executed opcode address.
// - Compressed rows: 2 info bits, 18 address bits, full on 64-byte cross.
// - Simultaneous matches: final-state match wins, else lowest channel.
module bmon_top
  import bmon_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Observed processor and background status
  input wire bmon_cpu_t CPU,
  input wire bmon_bdm_t BDM_STAT,
  // Breakpoint requests
  output logic BRK_BGND,
  output logic BRK_SWI
);

  // ****************************************
  // State
  // ****************************************
  logic [7:0] ctrl1, next_ctrl1;
  logic [7:0] tctrl, next_tctrl;
  logic [7:0] seq_ctl [3];
  logic [7:0] next_seq_ctl [3];
  logic [17:0] cmp [3];
  logic [17:0] next_cmp [3];
  logic [2:0] mflag, next_mflag;
  bmon_seq_t seq, next_seq;
  logic tracing, next_tracing;
  logic [BMON_PTR_W-1:0] wptr, next_wptr, tcount, next_tcount;
  logic [17:0] shadow, next_shadow, last_pc, next_last_pc;
  logic [BMON_ROW_W-1:0] tbuf [BMON_DEPTH];
  logic brk_pend, next_brk_pend;
  logic [31:0] next_prdata;
  logic next_pready, next_bgnd, next_swi;

  // ****************************************
  // Combinational decode
  // ****************************************
  bmon_mode_t mode;
  logic wr, rd, mapped, monitor_ok, hit_any, force_trigger_evt, trace_ok, store;
  logic [2:0] hit;
  logic [1:0] win;
  logic [BMON_ROW_W-1:0] row;

  // Channel leads to final state when its sequencer byte says so (bit 0)
  function automatic logic to_final(input logic [7:0] c);
    return c[0];
  endfunction

  assign mode = bmon_mode_t'(tctrl[3:2]);
  assign wr = PSEL & PENABLE & PWRITE & ~PREADY;
  assign rd = PSEL & PENABLE & ~PWRITE & ~PREADY;
  assign mapped = (PADDR <= BMON_OFS_TRACE_DATA) && (PADDR[1:0] == 2'h0);
  // Monitoring blocked by background access or active mode
  assign monitor_ok = CPU.valid & ~BDM_STAT.hw_access & ~BDM_STAT.active;
  // Tracing never while secured
  assign trace_ok = tctrl[BMON_TC_SRC] & ~BDM_STAT.secure;

  // Comparator hits and priority pick
  always_comb begin
    hit = 3'h0;
    win = 2'h3;
    for (int i = 0; i < 3; i++) begin
      hit[i] = monitor_ok & ctrl1[BMON_C1_ARM] & (CPU.addr == cmp[i]);
    end
    for (int i = 2; i >= 0; i--) begin
      if (hit[i]) begin
        win = 2'(i);
      end
    end
    for (int i = 2; i >= 0; i--) begin
      if (hit[i] && to_final(seq_ctl[i])) begin
        win = 2'(i);
      end
    end
  end
  assign hit_any = |hit;

  // Trace row builder and store qualifier
  always_comb begin
    store = 1'b0;
    row = {BMON_INFO_SHORT, CPU.addr};
    unique case (mode)
      BMON_MODE_NORMAL: begin
        store = CPU.cof_src | CPU.cof_dst | CPU.cof_vec;
      end
      BMON_MODE_LOOP: begin
        store = (CPU.cof_src & (CPU.addr != shadow)) | CPU.cof_dst | CPU.cof_vec;
      end
      BMON_MODE_DETAIL: begin
        store = ~CPU.free & ~CPU.fetch;
        row = {CPU.word, CPU.write, CPU.addr[17:8], CPU.data};
      end
      BMON_MODE_PURE_PC: begin
        store = CPU.opcode_exec;
        if (CPU.addr[17:BMON_PAGE_LSB] != last_pc[17:BMON_PAGE_LSB]) begin
          row = {BMON_INFO_FULL, CPU.addr};
        end else begin
          row = {BMON_INFO_SHORT, 12'h000, CPU.addr[BMON_PAGE_LSB-1:0]};
        end
      end
    endcase
    store = store & monitor_ok & tracing;
  end

  // ****************************************
  // Registers, sequencer, trace, breakpoints
  // ****************************************
  always_comb begin
    next_ctrl1 = ctrl1;
    next_tctrl = tctrl;
    next_seq_ctl = seq_ctl;
    next_cmp = cmp;
    next_mflag = mflag;
    next_seq = seq;
    next_tracing = tracing;
    next_wptr = wptr;
    next_tcount = tcount;
    next_shadow = shadow;
    next_last_pc = last_pc;
    next_brk_pend = 1'b0;
    force_trigger_evt = 1'b0;
    // Sequencer steps on a winning hit
    if (hit_any && seq != BMON_ST_IDLE) begin
      next_mflag = mflag | hit;
      if (to_final(seq_ctl[win])) begin
        force_trigger_evt = 1'b1;
      end else begin
        next_seq = (seq == BMON_ST_S3) ? BMON_ST_S1 : bmon_seq_t'(seq + 2'h1);
      end
    end
    // Trace storage
    if (store) begin
      next_wptr = wptr + 6'h01;
      next_tcount = tcount + 6'h01;
      next_shadow = CPU.addr;
      next_last_pc = CPU.addr;
      if (tctrl[BMON_TC_ALIGN] == 1'b0 && tcount == BMON_END_HALF) begin
        next_tracing = 1'b0;
        next_brk_pend = ctrl1[BMON_C1_BRK];
        next_ctrl1[BMON_C1_ARM] = 1'b0;
        next_seq = BMON_ST_IDLE;
      end
    end
    // Register writes
    if (wr) begin
      unique case (PADDR)
        BMON_OFS_CTRL1: begin
          next_ctrl1 = (PWDATA[7:0] & BMON_C1_WMASK) | (ctrl1 & ~BMON_C1_WMASK);
          if (PWDATA[BMON_C1_FORCE_TRIGGER] && PWDATA[BMON_C1_ARM]) begin
            next_ctrl1[BMON_C1_ARM] = 1'b0;
            next_seq = BMON_ST_IDLE;
            next_tracing = 1'b0;
          end else if (PWDATA[BMON_C1_ARM]) begin
            next_seq = BMON_ST_S1;
            next_mflag = 3'h0;
            next_tcount = 6'h00;
          end else begin
            next_seq = BMON_ST_IDLE;
          end
          if (PWDATA[BMON_C1_FORCE_TRIGGER] && !PWDATA[BMON_C1_ARM] && ctrl1[BMON_C1_ARM]) begin
            force_trigger_evt = 1'b1;
          end
        end
        BMON_OFS_TRACE_CTRL: next_tctrl = PWDATA[7:0];
        BMON_OFS_SEQ_WIN: begin
          if (ctrl1[1:0] != BMON_BANK_NONE) begin
            next_seq_ctl[ctrl1[1:0]] = PWDATA[7:0];
          end
        end
        BMON_OFS_CMP_A: next_cmp[0] = PWDATA[17:0];
        BMON_OFS_CMP_B: next_cmp[1] = PWDATA[17:0];
        BMON_OFS_CMP_C: next_cmp[2] = PWDATA[17:0];
        BMON_OFS_CMP_WIN: begin
          if (ctrl1[1:0] != BMON_BANK_NONE) begin
            next_cmp[ctrl1[1:0]] = PWDATA[17:0];
          end
        end
        default: ;
      endcase
    end
    // Trigger effect: tracing start or immediate break
    if (force_trigger_evt) begin
      if (trace_ok && !tracing) begin
        next_tracing = 1'b1;
        next_tcount = 6'h00;
      end else if (tracing) begin
        if (tctrl[BMON_TC_ALIGN]) begin
          next_tracing = 1'b0; // End aligned, trigger stops
          next_brk_pend = ctrl1[BMON_C1_BRK];
          next_ctrl1[BMON_C1_ARM] = 1'b0;
          next_seq = BMON_ST_IDLE;
        end // begin-aligned tracing runs on
      end else begin
        next_brk_pend = ctrl1[BMON_C1_BRK];
        next_ctrl1[BMON_C1_ARM] = 1'b0;
        next_seq = BMON_ST_IDLE;
      end
    end
    // Background entry by command keeps arm state: nothing to do here
  end

  // Breakpoint routing
  always_comb begin
    next_bgnd = 1'b0;
    next_swi = 1'b0;
    if (brk_pend && !(BDM_STAT.enabled && BDM_STAT.active && !BDM_STAT.secure)) begin
      if (ctrl1[BMON_C1_BDM]) begin
        next_bgnd = BDM_STAT.enabled;
        next_swi = ~BDM_STAT.enabled;
      end else begin
        next_swi = ~BDM_STAT.active;
      end
    end
  end

  // APB read mux and ready
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pready = PSEL & PENABLE & ~PREADY;
    if (rd) begin
      unique case (PADDR)
        BMON_OFS_CTRL1: next_prdata = {24'h00_0000, ctrl1 & ~(8'h01 << BMON_C1_FORCE_TRIGGER)};
        BMON_OFS_TRACE_CTRL: next_prdata = {24'h00_0000, tctrl};
        BMON_OFS_SEQ_WIN: begin
          if (ctrl1[1:0] == BMON_BANK_NONE) begin
            next_prdata = {29'h0000_0000, mflag};
          end else begin
            next_prdata = {24'h00_0000, seq_ctl[ctrl1[1:0]]};
          end
        end
        BMON_OFS_STATE: next_prdata = {29'h0000_0000, tracing, seq};
        BMON_OFS_CMP_A: next_prdata = {14'h0000, cmp[0]};
        BMON_OFS_CMP_B: next_prdata = {14'h0000, cmp[1]};
        BMON_OFS_CMP_C: next_prdata = {14'h0000, cmp[2]};
        BMON_OFS_CMP_WIN: begin
          if (ctrl1[1:0] != BMON_BANK_NONE) begin
            next_prdata = {14'h0000, cmp[ctrl1[1:0]]};
          end
        end
        BMON_OFS_TRACE_CNT: next_prdata = {26'h000_0000, tcount};
        BMON_OFS_TRACE_DATA: next_prdata = {12'h000, tbuf[PWDATA[BMON_PTR_W-1:0]]};
        default: ;
      endcase
    end
  end

  // Registered state
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl1 <= BMON_C1_RESET;
      tctrl <= BMON_TC_RESET;
      seq_ctl <= '{default: 8'h00};
      cmp <= '{default: 18'h00000};
      mflag <= 3'h0;
      seq <= BMON_ST_IDLE;
      tracing <= 1'b0;
      wptr <= 6'h00;
      tcount <= 6'h00;
      shadow <= 18'h00000;
      last_pc <= 18'h00000;
      brk_pend <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      BRK_BGND <= 1'b0;
      BRK_SWI <= 1'b0;
    end else begin
      ctrl1 <= next_ctrl1;
      tctrl <= next_tctrl;
      seq_ctl <= next_seq_ctl;
      cmp <= next_cmp;
      mflag <= next_mflag;
      seq <= next_seq;
      tracing <= next_tracing;
      wptr <= next_wptr;
      tcount <= next_tcount;
      shadow <= next_shadow;
      last_pc <= next_last_pc;
      brk_pend <= next_brk_pend;
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pready & ~mapped;
      BRK_BGND <= next_bgnd;
      BRK_SWI <= next_swi;
    end
  end

  // Trace memory, no reset
  always_ff @(posedge MCLK) begin
    if (store) begin
      tbuf[wptr] <= row;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_no_trace_secure;
    @(posedge MCLK) disable iff (!RESET_N) BDM_STAT.secure |-> ##1 !(tracing && $rose(tracing));
  endproperty
  a_no_trace_secure: assert property (p_no_trace_secure) else $error("trace started while secure");

  property p_bgnd_blocks;
    @(posedge MCLK) disable iff (!RESET_N) (BDM_STAT.active || BDM_STAT.hw_access) |-> ##1 ($stable(mflag) || mflag == 3'h0);
  endproperty
  a_bgnd_blocks: assert property (p_bgnd_blocks) else $error("match seen in background");

  property p_arm_seq;
    @(posedge MCLK) disable iff (!RESET_N) (wr && PADDR == BMON_OFS_CTRL1 && PWDATA[BMON_C1_ARM] && !PWDATA[BMON_C1_FORCE_TRIGGER])
      |=> (seq == BMON_ST_S1 && ctrl1[BMON_C1_ARM]);
  endproperty
  a_arm_seq: assert property (p_arm_seq) else $error("arm did not enter first state");

  property p_force_trigger_reads_zero;
    @(posedge MCLK) disable iff (!RESET_N) (rd && PADDR == BMON_OFS_CTRL1) |=> !PRDATA[BMON_C1_FORCE_TRIGGER];
  endproperty
  a_force_trigger_reads_zero: assert property (p_force_trigger_reads_zero) else $error("trigger bit read as one");

  property p_end_session;
    @(posedge MCLK) disable iff (!RESET_N) (wr && PADDR == BMON_OFS_CTRL1 && PWDATA[BMON_C1_FORCE_TRIGGER] && PWDATA[BMON_C1_ARM])
      |=> (!ctrl1[BMON_C1_ARM] && seq == BMON_ST_IDLE && !tracing);
  endproperty
  a_end_session: assert property (p_end_session) else $error("session not ended");

  sequence s_brk;
    brk_pend && ctrl1[BMON_C1_BDM] && !BDM_STAT.enabled;
  endsequence
  property p_swi_fallback;
    @(posedge MCLK) disable iff (!RESET_N) s_brk |=> (BRK_SWI && !BRK_BGND);
  endproperty
  a_swi_fallback: assert property (p_swi_fallback) else $error("no software interrupt fallback");

  property p_no_brk_disabled;
    @(posedge MCLK) disable iff (!RESET_N) !ctrl1[BMON_C1_BRK] |=> ##1 !(BRK_SWI || BRK_BGND);
  endproperty
  a_no_brk_disabled: assert property (p_no_brk_disabled) else $error("break without request enable");

  property p_loop_dup;
    @(posedge MCLK) disable iff (!RESET_N) (mode == BMON_MODE_LOOP && CPU.cof_src && !CPU.cof_dst && !CPU.cof_vec
      && CPU.addr == shadow) |-> !store;
  endproperty
  a_loop_dup: assert property (p_loop_dup) else $error("duplicate source stored");

  property p_detail_skip;
    @(posedge MCLK) disable iff (!RESET_N) (mode == BMON_MODE_DETAIL && (CPU.free || CPU.fetch)) |=> $stable(wptr);
  endproperty
  a_detail_skip: assert property (p_detail_skip) else $error("free or fetch cycle traced");

endmodule

// ### bench/bmon_cpu_model.sv
// Model of the processor bus and background status seen by the bus monitor
`timescale 1ns/1ns
module bmon_cpu_model
  import bmon_pkg::*;
(
  // Clock
  input wire logic MCLK,
  // Observed activity
  output bmon_cpu_t CPU,
  output bmon_bdm_t BDM_STAT
);
  // ****************************************
  // Initial idle state
  // ****************************************
  initial begin
    CPU = '0;
    BDM_STAT = '0;
  end

  // ****************************************
  // Stimulus tasks
  // ****************************************
  // One bus cycle, then idle with inverted address and data and cleared flags so stale values never match
  task automatic issue(input logic [17:0] a, input logic [7:0] d, input logic [7:0] k);
    @(posedge MCLK);
    CPU <= {1'b1, a, d, k};
    @(posedge MCLK);
    CPU <= {1'b0, ~a, ~d, 8'h00};
  endtask

  // Background enable, active, hardware access, secure, background command
  task automatic mode(input logic [4:0] m);
    @(posedge MCLK);
    BDM_STAT <= m;
  endtask
endmodule

// ### bench/testbench.sv
// Self-checking testbench of the bus monitor
`timescale 1ns/1ns
module testbench;
  import bmon_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic MCLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, BRK_BGND, BRK_SWI, rerr;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdata;
  bmon_cpu_t cpu;
  bmon_bdm_t background_debug_mode;
  int n_fail, comparisons, cycles;
  localparam logic [17:0] A1 = 18'h00400;
  localparam logic [7:0] K_FETCH = 8'h10;
  localparam logic [7:0] K_EXEC = 8'h08;
  logic [31:0] cmpv [3] = '{32'h400, 32'h800, 32'hc00};

  // Design and processor model
  bmon_top u_bmon_top (.MCLK(MCLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CPU(cpu), .BDM_STAT(background_debug_mode), .BRK_BGND(BRK_BGND), .BRK_SWI(BRK_SWI));
  bmon_cpu_model u_bmon_cpu_model (.MCLK(MCLK), .CPU(cpu), .BDM_STAT(background_debug_mode));

  // Clock and hang guard
  initial MCLK = 1'b0;
  always #4 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  // APB transfer: setup, access until ready, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1);
    rdata = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Answer stands one cycle after the first access edge
    chk("pready_wait", 32'h2, n);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string s, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    apb(1'b0, a, d);
    chk(s, e, rdata);
  endtask

  // Collect breakpoint pulses over a short window
  task automatic brk(input logic [1:0] e);
    logic [1:0] g;
    g = 2'b00;
    repeat (8) begin
      @(posedge MCLK);
      g = g | {BRK_BGND, BRK_SWI};
    end
    chk("breakpoint", {30'h0, e}, {30'h0, g});
  endtask

  // Arm with given mode, hit comparator A, check pulses and control after
  task automatic bcase(input logic [4:0] m, input logic [7:0] c, input logic [1:0] e, input logic [7:0] a);
    u_bmon_cpu_model.mode(m);
    wr(BMON_OFS_CTRL1, {24'h0, c});
    u_bmon_cpu_model.issue(A1, 8'h00, K_FETCH);
    brk(e);
    if (a != 8'hff) rdc("ctrl1_after", BMON_OFS_CTRL1, 32'h0, {24'h0, a});
  endtask

  task automatic tstart(input logic [7:0] tc);
    wr(BMON_OFS_TRACE_CTRL, {24'h0, tc});
    wr(BMON_OFS_CTRL1, 32'h80);
    // Comparator A match is the trigger that opens the session
    u_bmon_cpu_model.issue(A1, 8'h00, K_FETCH);
  endtask

  task automatic tend(input string s, input logic [31:0] e);
    u_bmon_cpu_model.issue(A1, 8'h00, K_FETCH);
    repeat (4) @(posedge MCLK);
    rdc(s, BMON_OFS_TRACE_CNT, 32'h0, e);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    RESET_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    repeat (10) @(posedge MCLK);
    RESET_N <= 1'b1;
    rdc("ctrl1", BMON_OFS_CTRL1, 32'h0, {24'h0, BMON_C1_RESET});
    rdc("trace_ctrl", BMON_OFS_TRACE_CTRL, 32'h0, {24'h0, BMON_TC_RESET});
    apb(1'b0, 12'h028, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    chk("unmapped_data", 32'h0, rdata);
    $display("test reset_map done");
    for (int b = 0; b < 3; b++) begin
      wr(BMON_OFS_CMP_A + 12'(4 * b), cmpv[b]);
      wr(BMON_OFS_CTRL1, b);
      wr(BMON_OFS_SEQ_WIN, 32'h1 << b);
    end
    for (int b = 0; b < 3; b++) begin
      wr(BMON_OFS_CTRL1, b);
      rdc("seq_win", BMON_OFS_SEQ_WIN, 32'h0, 32'h1 << b);
      rdc("cmp_win", BMON_OFS_CMP_WIN, 32'h0, cmpv[b]);
    end
    wr(BMON_OFS_CTRL1, 32'h4b);
    rdc("ctrl1_force_trigger", BMON_OFS_CTRL1, 32'h0, 32'h0b);
    $display("test banks done");
    bcase(5'h10, 8'h98, 2'b10, 8'h18);
    bcase(5'h00, 8'h98, 2'b01, 8'h18);
    bcase(5'h10, 8'h88, 2'b01, 8'h08);
    bcase(5'h18, 8'h88, 2'b00, 8'h88);
    bcase(5'h19, 8'h98, 2'b00, 8'h98);
    rdc("state", BMON_OFS_STATE, 32'h0, 32'h1);
    bcase(5'h14, 8'h98, 2'b00, 8'h98);
    bcase(5'h12, 8'h98, 2'b10, 8'h18);
    bcase(5'h10, 8'h90, 2'b00, 8'hff);
    wr(BMON_OFS_CTRL1, 32'h98);
    wr(BMON_OFS_CTRL1, 32'hd8);
    rdc("ctrl1_end", BMON_OFS_CTRL1, 32'h0, 32'h18);
    $display("test breakpoints done");
    tstart({4'h0, BMON_MODE_NORMAL, 2'b11});
    u_bmon_cpu_model.issue(18'h00100, 8'h11, 8'h40);
    u_bmon_cpu_model.issue(18'h00200, 8'h00, 8'h04);
    tend("normal_cnt", 32'h1);
    tstart({4'h0, BMON_MODE_LOOP, 2'b11});
    // Base kept clear of the last address stored by the session before
    for (int i = 0; i < 6; i++) u_bmon_cpu_model.issue(18'h00300 + 18'(i / 2), 8'h00, 8'h04 >> (i / 2));
    tend("loop_cnt", 32'h5);
    tstart({4'h0, BMON_MODE_DETAIL, 2'b11});
    u_bmon_cpu_model.issue(18'h2abcd, 8'h5a, 8'h40);
    u_bmon_cpu_model.issue(18'h00600, 8'h00, 8'h20);
    u_bmon_cpu_model.issue(18'h00700, 8'h00, K_FETCH);
    u_bmon_cpu_model.issue(18'h00123, 8'h3c, 8'h80);
    tend("detail_cnt", 32'h2);
    // Write pointer runs on across sessions: 1 normal row, 5 loop rows before these
    rdc("detail_row0", BMON_OFS_TRACE_DATA, 32'h6, {12'h0, 2'b10, 10'h2ab, 8'h5a});
    rdc("detail_row1", BMON_OFS_TRACE_DATA, 32'h7, {12'h0, 2'b01, 10'h001, 8'h3c});
    tstart({4'h0, BMON_MODE_PURE_PC, 2'b11});
    u_bmon_cpu_model.issue(18'h01000, 8'h00, K_EXEC);
    u_bmon_cpu_model.issue(18'h01004, 8'h00, K_EXEC);
    u_bmon_cpu_model.issue(18'h01040, 8'h00, K_EXEC);
    tend("pc_cnt", 32'h3);
    apb(1'b0, BMON_OFS_TRACE_DATA, 32'h9);
    chk("pc_info1", {30'h0, BMON_INFO_SHORT}, {30'h0, rdata[19:18]});
    apb(1'b0, BMON_OFS_TRACE_DATA, 32'ha);
    chk("pc_info2", {30'h0, BMON_INFO_FULL}, {30'h0, rdata[19:18]});
    // Begin-aligned tracing runs on past a forced trigger, then a forced end
    tstart({4'h0, BMON_MODE_DETAIL, 2'b01});
    wr(BMON_OFS_CTRL1, 32'h40);
    rdc("begin_force_trigger", BMON_OFS_STATE, 32'h0, 32'h4);
    wr(BMON_OFS_CTRL1, 32'hc0);
    rdc("end_state", BMON_OFS_STATE, 32'h0, 32'h0);
    tstart({4'h0, BMON_MODE_DETAIL, 2'b10});
    u_bmon_cpu_model.issue(18'h00123, 8'h3c, 8'h80);
    tend("nosrc_cnt", 32'h0);
    u_bmon_cpu_model.mode(5'h12);
    // Armed and secured: a forced trigger must not open tracing
    wr(BMON_OFS_TRACE_CTRL, {24'h0, 4'h0, BMON_MODE_DETAIL, 2'b01});
    wr(BMON_OFS_CTRL1, 32'h80);
    wr(BMON_OFS_CTRL1, 32'h40);
    rdc("secure_force_trigger", BMON_OFS_STATE, 32'h0, 32'h0);
    tstart({4'h0, BMON_MODE_DETAIL, 2'b11});
    u_bmon_cpu_model.issue(18'h00123, 8'h3c, 8'h80);
    tend("secure_cnt", 32'h0);
    $display("test trace done");
    wrap_up();
  end
endmodule
